// ---- src/epi_cfg.svh ----
// register indices, field positions, reset values and timing counts of the pin interrupt unit
// Summary of operation
// R1: upper pins 7..4 request only with global enable and their enable bit set
// R2: upper pins are sampled by the clock; pulses over one period are caught
// R3: sense field 00 low, 01 any change, 10 falling, 11 rising edge
// R4: a low-level source holds the pin low until the current instruction ends
// R5: enabled low-level pin requests for as long as it stays low
// R6: software disables a pin before changing its sense bits
// R7: eight enable bits with global enable gate each pin; sense picks the trigger; here pins 3..0 have no sense field and trigger on any change
// R8: pin activity triggers even while the pin is driven as an output
// R9: a triggering edge or change sets the pin flag; vector needs both enables
// R10: flags clear on vector entry or on writing a one
// R11: a pin flag stays clear while that pin uses low-level sensing
// R12: sleep with lower pins disabled gates their buffers and may set flags 3..0
// R13: group 2 enable and global enable let unmasked inputs 23..16 request
// R14: group 1 enable and global enable let unmasked inputs 15..8 request
// R15: group 0 enable and global enable let unmasked inputs 7..0 request
// R16: a change in a group sets that group's flag, bits 2, 1, 0
// R17: a mask bit enables its own input only together with its group enable
// R18: change detection works on all twenty-four inputs for wake from sleep; here detection is clocked, so the clock must keep running
// R19: upper edge recognition needs the running clock
// R20: enables, masks, sense bits and flags reset to zero; reserved bits read zero
// R21: an acknowledge pulse clears its flag; requests follow flag and enables
`ifndef EPI_CFG_SVH
`define EPI_CFG_SVH
`define EPI_IDX_CHG_FLAG 10'h03B
`define EPI_IDX_EXT_FLAG 10'h03C
`define EPI_IDX_EXT_EN 10'h03D
`define EPI_IDX_CHG_EN 10'h068
`define EPI_IDX_UP_SENSE 10'h06A
`define EPI_IDX_MASK0 10'h06B
`define EPI_IDX_MASK1 10'h06C
`define EPI_IDX_MASK2 10'h06D
`define EPI_IDX_GLOBAL 10'h070
`define EPI_GLOBAL_EN_BIT 0
`define EPI_UPPER_LO 4
`define EPI_SENSE_W 2
`define EPI_RESET_BYTE 8'h00
`define EPI_PIN_IDLE 1'b1
`define EPI_SYNC_STAGES 2
`endif

// ---- src/epi_pkg.sv ----
// types shared by the pin interrupt unit
package epi_pkg;
  typedef enum logic [1:0]
  {
    epi_sense_low = 2'b00,
    epi_sense_any = 2'b01,
    epi_sense_fall = 2'b10,
    epi_sense_rise = 2'b11
  } epi_sense_t;
  typedef struct packed
  {
    logic [2:0] chg;
    logic [7:0] ext;
  } epi_irq_t;
endpackage : epi_pkg

// ---- src/epi_sync.sv ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
`include "epi_cfg.svh"
module epi_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  if (W < 1 || `EPI_SYNC_STAGES != 2)
  begin : g_chk
    $error("epi_sync: width must be positive");
  end
  // pins idle high, so reset to that level to avoid a false change at release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= {W{`EPI_PIN_IDLE}};
      q <= {W{`EPI_PIN_IDLE}};
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : epi_sync
`default_nettype wire

// ---- src/epi_top.sv ----
// external pin and pin-change interrupt unit with an APB register slave
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "epi_cfg.svh"
module epi_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] ext_irq_pins,
  input wire logic [23:0] change_inputs,
  input wire logic sleep_active,
  input wire epi_pkg::epi_irq_t irq_ack,
  output epi_pkg::epi_irq_t irq_req
);
  if (ADDR_W < 12)
  begin : g_chk
    $error("epi_top: address too narrow for the register map");
  end

  function automatic logic is_idx(input logic [9:0] idx, input logic [9:0] want);
    is_idx = (idx == want);
  endfunction : is_idx

  logic gie;
  logic [7:0] ext_pin_enable_reg;
  logic [7:0] ext_pin_flags;
  logic [7:0] upper_sense_reg;
  logic [2:0] change_group_enable_reg;
  logic [2:0] change_group_flag_reg;
  logic [7:0] change_mask [3];
  logic [7:0] ext_s;
  logic [7:0] ext_view;
  logic [7:0] ext_p;
  logic [23:0] chg_s;
  logic [23:0] chg_p;
  logic [7:0] ext_hit;
  logic [7:0] upper_level;
  logic [2:0] group_hit;
  logic [7:0] next_ext_flag;
  logic [2:0] next_chg_flag;
  logic [9:0] idx;
  logic wr;
  logic [7:0] wbyte;
  logic mapped;

  // pins cross into the clock domain before any edge logic sees them
  epi_sync #(.W(8)) u_ext_sync ( // R2 R19
    .clk_sys(clk_sys),
    .rst(rst),
    .d(ext_irq_pins),
    .q(ext_s)
  );
  // true asynchronous detection is traded for a clean synchronous design;
  // wake from deep sleep needs this clock kept running
  epi_sync #(.W(24)) u_chg_sync ( // R18
    .clk_sys(clk_sys),
    .rst(rst),
    .d(change_inputs),
    .q(chg_s)
  );

  assign idx = paddr[11:2];
  assign wbyte = pwdata[7:0];
  assign wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];

  always_comb
  begin
    mapped = 1'b0;
    case (idx)
      `EPI_IDX_CHG_FLAG, `EPI_IDX_EXT_FLAG, `EPI_IDX_EXT_EN, `EPI_IDX_CHG_EN,
      `EPI_IDX_UP_SENSE, `EPI_IDX_MASK0, `EPI_IDX_MASK1, `EPI_IDX_MASK2,
      `EPI_IDX_GLOBAL: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // lower pin buffers are switched off in sleep when disabled; the forced
  // level can look like a change and set their flags
  always_comb
  begin
    ext_view = ext_s;
    ext_view[3:0] = ext_s[3:0] | ({4{sleep_active}} & ~ext_pin_enable_reg[3:0]); // R12
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_p <= {8{`EPI_PIN_IDLE}};
      chg_p <= {24{`EPI_PIN_IDLE}};
    end
    else
    begin
      ext_p <= ext_view;
      chg_p <= chg_s;
    end
  end

  // per-pin trigger; direction of the pin plays no part here
  for (genvar g = 0; g < 8; g++)
  begin : g_pin
    if (g >= `EPI_UPPER_LO)
    begin : g_up
      epi_pkg::epi_sense_t mode;
      assign mode = epi_pkg::epi_sense_t'(upper_sense_reg[`EPI_SENSE_W*(g-`EPI_UPPER_LO) +: `EPI_SENSE_W]);
      always_comb
      begin
        ext_hit[g] = 1'b0;
        upper_level[g] = 1'b0;
        case (mode) // R3 R8
          epi_pkg::epi_sense_low: upper_level[g] = 1'b1;
          epi_pkg::epi_sense_any: ext_hit[g] = ext_view[g] ^ ext_p[g];
          epi_pkg::epi_sense_fall: ext_hit[g] = ext_p[g] && !ext_view[g];
          epi_pkg::epi_sense_rise: ext_hit[g] = !ext_p[g] && ext_view[g];
          default: ext_hit[g] = 1'b0;
        endcase
      end
    end
    else
    begin : g_lo
      // lower sense control lives elsewhere; any change counts here
      always_comb
      begin
        ext_hit[g] = ext_view[g] ^ ext_p[g];
        upper_level[g] = 1'b0;
      end
    end
  end

  for (genvar k = 0; k < 3; k++)
  begin : g_grp
    // R13 R14 R15 R17
    assign group_hit[k] = change_group_enable_reg[k] && (|((chg_s[8*k +: 8] ^ chg_p[8*k +: 8]) & change_mask[k]));
  end

  // a new event wins over a clear in the same cycle
  always_comb
  begin
    logic [7:0] ext_clr;
    logic [2:0] chg_clr;
    ext_clr = irq_ack.ext; // R10 R21
    chg_clr = irq_ack.chg; // R10 R21
    if (wr && is_idx(idx, `EPI_IDX_EXT_FLAG))
    begin
      ext_clr = ext_clr | wbyte; // R10
    end
    if (wr && is_idx(idx, `EPI_IDX_CHG_FLAG))
    begin
      chg_clr = chg_clr | wbyte[2:0]; // R10
    end
    next_ext_flag = ((ext_pin_flags & ~ext_clr) | ext_hit) & ~upper_level; // R9 R11
    next_chg_flag = (change_group_flag_reg & ~chg_clr) | group_hit; // R16
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_pin_flags <= `EPI_RESET_BYTE; // R20
      change_group_flag_reg <= 3'h0;
    end
    else
    begin
      ext_pin_flags <= next_ext_flag;
      change_group_flag_reg <= next_chg_flag;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gie <= 1'b0; // R20
      ext_pin_enable_reg <= `EPI_RESET_BYTE;
      upper_sense_reg <= `EPI_RESET_BYTE;
      change_group_enable_reg <= 3'h0;
      change_mask[0] <= `EPI_RESET_BYTE;
      change_mask[1] <= `EPI_RESET_BYTE;
      change_mask[2] <= `EPI_RESET_BYTE;
    end
    else if (wr)
    begin
      if (is_idx(idx, `EPI_IDX_GLOBAL))
      begin
        gie <= wbyte[`EPI_GLOBAL_EN_BIT];
      end
      if (is_idx(idx, `EPI_IDX_EXT_EN))
      begin
        ext_pin_enable_reg <= wbyte;
      end
      // sense may change while enabled; software is expected to disable first
      if (is_idx(idx, `EPI_IDX_UP_SENSE))
      begin
        upper_sense_reg <= wbyte; // R6
      end
      if (is_idx(idx, `EPI_IDX_CHG_EN))
      begin
        change_group_enable_reg <= wbyte[2:0];
      end
      if (is_idx(idx, `EPI_IDX_MASK0))
      begin
        change_mask[0] <= wbyte;
      end
      if (is_idx(idx, `EPI_IDX_MASK1))
      begin
        change_mask[1] <= wbyte;
      end
      if (is_idx(idx, `EPI_IDX_MASK2))
      begin
        change_mask[2] <= wbyte;
      end
    end
  end

  // requests follow the next flag so an acknowledged vector drops at once;
  // a low-level pin requests straight from the sampled pin
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_req <= '0;
    end
    else
    begin
      irq_req.ext <= {8{gie}} & ext_pin_enable_reg
                     & (next_ext_flag | (upper_level & ~ext_s)); // R1 R4 R5 R7 R9
      irq_req.chg <= {3{gie}} & change_group_enable_reg & next_chg_flag; // R13 R14 R15 R21
    end
  end

  // no wait state: read data and answer are captured in the setup cycle; writes land in the access cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && mapped)
      begin
        case (idx) // R20
          `EPI_IDX_CHG_FLAG: prdata[2:0] <= change_group_flag_reg;
          `EPI_IDX_EXT_FLAG: prdata[7:0] <= ext_pin_flags;
          `EPI_IDX_EXT_EN: prdata[7:0] <= ext_pin_enable_reg;
          `EPI_IDX_CHG_EN: prdata[2:0] <= change_group_enable_reg;
          `EPI_IDX_UP_SENSE: prdata[7:0] <= upper_sense_reg;
          `EPI_IDX_MASK0: prdata[7:0] <= change_mask[0];
          `EPI_IDX_MASK1: prdata[7:0] <= change_mask[1];
          `EPI_IDX_MASK2: prdata[7:0] <= change_mask[2];
          `EPI_IDX_GLOBAL: prdata[`EPI_GLOBAL_EN_BIT] <= gie;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks, helper causes computed apart from the main decode
  logic [7:0] rise_cause;
  logic [7:0] fall_cause;
  always_comb
  begin
    rise_cause = 8'h00;
    fall_cause = 8'h00;
    for (int i = `EPI_UPPER_LO; i < 8; i++)
    begin
      rise_cause[i] = (upper_sense_reg[2*i-8 +: 2] == 2'h3) && !ext_p[i] && ext_s[i];
      fall_cause[i] = (upper_sense_reg[2*i-8 +: 2] == 2'h2) && ext_p[i] && !ext_s[i];
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
    s_setup |=> s_answer)
    else $error("apb answer not one cycle after setup");
  a_ext_req_gate: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (irq_req.ext & ~$past(ext_pin_enable_reg & {8{gie}})) == 8'h00)
    else $error("pin request without enables");
  a_level_req_held: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (gie && ext_pin_enable_reg[7] && upper_sense_reg[7:6] == 2'h0 && !ext_s[7])[*2] |=> irq_req.ext[7])
    else $error("held low level did not request");
  a_level_flag_clear: assert property (@(posedge clk_sys) disable iff (rst) // R11
    (ext_pin_flags & $past(upper_level)) == 8'h00)
    else $error("flag set in low level mode");
  a_rise_sets_flag: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (rise_cause != 8'h00) |=> ((ext_pin_flags & $past(rise_cause)) == $past(rise_cause)))
    else $error("rising edge lost");
  a_fall_sets_flag: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (fall_cause != 8'h00) |=> ((ext_pin_flags & $past(fall_cause)) == $past(fall_cause)))
    else $error("falling edge lost");
  a_group_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // R16
    group_hit[2] |=> change_group_flag_reg[2])
    else $error("group change lost");
  a_masked_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R17
    $rose(change_group_flag_reg[0]) |-> $past(change_group_enable_reg[0] && (change_mask[0] != 8'h00)))
    else $error("group flag set while masked");
  a_ack_clears: assert property (@(posedge clk_sys) disable iff (rst) // R21
    (irq_ack.chg[1] && !group_hit[1]) |=> !change_group_flag_reg[1] && !irq_req.chg[1])
    else $error("acknowledge did not clear");
  a_w1c_clears: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (wr && idx == `EPI_IDX_EXT_FLAG && wbyte[0] && !ext_hit[0]) |=> !ext_pin_flags[0])
    else $error("write one did not clear flag");
  a_chg_req_gate: assert property (@(posedge clk_sys) disable iff (rst) // R15
    irq_req.chg[0] |-> $past(gie && change_group_enable_reg[0]) ##0 change_group_flag_reg[0])
    else $error("group request without cause");
  // lower pins have no sense field here, so their change path is checked apart
  a_lo_change_flag: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (ext_view[0] != ext_p[0]) |=> ext_pin_flags[0])
    else $error("lower pin change lost");
  a_sleep_sets_flag: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (sleep_active && !ext_pin_enable_reg[2] && !ext_p[2]) |=> ext_pin_flags[2])
    else $error("sleep buffer change lost");
  a_grp2_req_gate: assert property (@(posedge clk_sys) disable iff (rst) // R13
    irq_req.chg[2] |-> $past(gie && change_group_enable_reg[2]))
    else $error("group 2 request without enables");
  a_grp1_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // R14
    group_hit[1] |=> change_group_flag_reg[1])
    else $error("group 1 change lost");
  a_req_needs_gie: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (|irq_req) |-> $past(gie))
    else $error("request without global enable");
endmodule : epi_top
`default_nettype wire

// ---- dv/epi_pin_drv.sv ----
// far-side driver of the external and pin-change input pins
`timescale 1ns/10ps
`default_nettype none
module epi_pin_drv (
  input wire logic clk_sys,
  output var logic [7:0] ext_irq_pins,
  output var logic [23:0] change_inputs
);
  // pins rest high, as with the port pull-ups on
  initial ext_irq_pins = 8'hFF;
  initial change_inputs = 24'hFFFFFF;
  // a low level is held for many cycles, past any instruction in flight
  task automatic ext_hold(input int i, input logic v, input int n);
    ext_irq_pins[i] <= v;
    repeat (n) @(posedge clk_sys);
  endtask : ext_hold
  // two periods low, longer than the one-period minimum
  task automatic ext_pulse(input int i);
    ext_hold(i, 1'b0, 2);
    ext_hold(i, 1'b1, 5);
  endtask : ext_pulse
  task automatic chg_pulse(input int i);
    change_inputs[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    change_inputs[i] <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask : chg_pulse
endmodule : epi_pin_drv
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the pin interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "epi_cfg.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_active = 1'b0;
  epi_pkg::epi_irq_t irq_ack = 11'h000;
  epi_pkg::epi_irq_t irq_req;
  wire logic [7:0] ext_irq_pins;
  wire logic [23:0] change_inputs;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rq;
  logic re;
  logic [9:0] regs [9] = '{`EPI_IDX_CHG_FLAG, `EPI_IDX_EXT_FLAG, `EPI_IDX_EXT_EN, `EPI_IDX_CHG_EN,
    `EPI_IDX_UP_SENSE, `EPI_IDX_MASK0, `EPI_IDX_MASK1, `EPI_IDX_MASK2, `EPI_IDX_GLOBAL};

  always #4 clk_sys = ~clk_sys;

  epi_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pins(ext_irq_pins), .change_inputs(change_inputs),
    .sleep_active(sleep_active), .irq_ack(irq_ack), .irq_req(irq_req));

  epi_pin_drv pins (.clk_sys(clk_sys), .ext_irq_pins(ext_irq_pins), .change_inputs(change_inputs));

  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // request held until the rising edge that samples pready high; answer taken at that edge
  // upper write data bits carry filler, since only the low byte may matter
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= {24'hA5A5A5, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, d, 4'hF, rq, re);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx, 2'b00}, 8'h00, 4'hF, rq, re);
    chk($sformatf("register %h", idx), {24'h000000, exp}, rq);
    chk($sformatf("error %h", idx), 32'h00000000, {31'h0, re});
  endtask : rd

  task automatic req(input logic [10:0] exp);
    @(negedge clk_sys);
    chk("irq_req", {21'h00000, exp}, {21'h00000, irq_req});
    @(posedge clk_sys);
  endtask : req

  task automatic ack(input logic [10:0] v);
    irq_ack <= v;
    @(posedge clk_sys);
    irq_ack <= 11'h000;
    @(posedge clk_sys);
  endtask : ack

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (regs[i]) rd(regs[i], 8'h00);
    apb(1'b0, 12'h004, 8'h00, 4'hF, rq, re);
    chk("pslverr", 32'h00000001, {31'h0, re});
    apb(1'b0, {`EPI_IDX_EXT_EN, 2'b10}, 8'h00, 4'hF, rq, re);
    chk("misaligned pslverr", 32'h00000001, {31'h0, re});
    chk("misaligned prdata", 32'h00000000, rq);
    // sense fields are set while every pin is still disabled
    wr(`EPI_IDX_UP_SENSE, 8'h3E);
    wr(`EPI_IDX_GLOBAL, 8'h01);
    wr(`EPI_IDX_EXT_EN, 8'hF1);
    rd(`EPI_IDX_EXT_EN, 8'hF1);
    // a write without the low byte strobe must leave the register alone
    apb(1'b1, {`EPI_IDX_EXT_EN, 2'b00}, 8'h00, 4'hE, rq, re);
    rd(`EPI_IDX_EXT_EN, 8'hF1);
    pins.ext_pulse(4);
    req(11'h010);
    pins.ext_pulse(5);
    req(11'h030);
    pins.ext_pulse(6);
    req(11'h070);
    rd(`EPI_IDX_EXT_FLAG, 8'h70);
    wr(`EPI_IDX_EXT_FLAG, 8'h10);
    rd(`EPI_IDX_EXT_FLAG, 8'h60);
    ack(11'h060);
    req(11'h000);
    pins.ext_hold(7, 1'b0, 5);
    req(11'h080);
    rd(`EPI_IDX_EXT_FLAG, 8'h00);
    pins.ext_hold(7, 1'b1, 5);
    req(11'h000);
    wr(`EPI_IDX_GLOBAL, 8'h00);
    pins.ext_pulse(4);
    req(11'h000);
    rd(`EPI_IDX_EXT_FLAG, 8'h10);
    wr(`EPI_IDX_GLOBAL, 8'h01);
    wr(`EPI_IDX_EXT_EN, 8'h00);
    req(11'h000);
    wr(`EPI_IDX_EXT_EN, 8'h10);
    req(11'h010);
    wr(`EPI_IDX_EXT_FLAG, 8'hFF);
    req(11'h000);
    pins.ext_pulse(0);
    rd(`EPI_IDX_EXT_FLAG, 8'h01);
    wr(`EPI_IDX_EXT_FLAG, 8'h01);
    rd(`EPI_IDX_EXT_FLAG, 8'h00);
    // lower pin 2 held low, then its buffer is forced off by sleep
    pins.ext_hold(2, 1'b0, 5);
    wr(`EPI_IDX_EXT_FLAG, 8'h04);
    rd(`EPI_IDX_EXT_FLAG, 8'h00);
    sleep_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(`EPI_IDX_EXT_FLAG, 8'h04);
    sleep_active <= 1'b0;
    pins.ext_hold(2, 1'b1, 5);
    wr(`EPI_IDX_CHG_EN, 8'hFF);
    rd(`EPI_IDX_CHG_EN, 8'h07);
    wr(`EPI_IDX_MASK0, 8'h01);
    wr(`EPI_IDX_MASK1, 8'h80);
    rd(`EPI_IDX_MASK1, 8'h80);
    pins.chg_pulse(1);
    pins.chg_pulse(16);
    req(11'h000);
    pins.chg_pulse(0);
    pins.chg_pulse(15);
    req(11'h300);
    rd(`EPI_IDX_CHG_FLAG, 8'h03);
    wr(`EPI_IDX_MASK2, 8'h01);
    pins.chg_pulse(16);
    req(11'h700);
    ack(11'h200);
    req(11'h500);
    wr(`EPI_IDX_GLOBAL, 8'h00);
    req(11'h000);
    wr(`EPI_IDX_CHG_FLAG, 8'hFF);
    rd(`EPI_IDX_CHG_FLAG, 8'h00);
    rd(`EPI_IDX_EXT_FLAG, 8'h04);
    // a second reset in mid-run must bring the pin flag and pin enable registers back to zero
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`EPI_IDX_EXT_FLAG, 8'h00);
    rd(`EPI_IDX_EXT_EN, 8'h00);
    req(11'h000);
    wrap_up();
  end

  // the sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
